// >>> inc/cfg_defines.svh
// Constants for the configuration register one block
`ifndef CFG_DEFINES_SVH
`define CFG_DEFINES_SVH

// Command opcodes
`define CFG_OP_WRR      8'h01
`define CFG_OP_WRDI     8'h04
`define CFG_OP_RDSR     8'h05
`define CFG_OP_WREN     8'h06
`define CFG_OP_CLSR     8'h30
`define CFG_OP_RDCR     8'h35
`define CFG_OP_RESET    8'hf0
`define CFG_OP_READ3    8'h03
`define CFG_OP_READ4    8'h13
`define CFG_OP_FR3      8'h0b
`define CFG_OP_FR4      8'h0c
`define CFG_OP_DOR3     8'h3b
`define CFG_OP_DOR4     8'h3c
`define CFG_OP_QOR3     8'h6b
`define CFG_OP_QOR4     8'h6c
`define CFG_OP_DIO3     8'hbb
`define CFG_OP_DIO4     8'hbc
`define CFG_OP_QIO3     8'heb
`define CFG_OP_QIO4     8'hec
`define CFG_OP_DFR3     8'h0d
`define CFG_OP_DFR4     8'h0e
`define CFG_OP_DDIO3    8'hbd
`define CFG_OP_DDIO4    8'hbe
`define CFG_OP_DQIO3    8'hed
`define CFG_OP_DQIO4    8'hee

// Configuration register one field positions
`define CFG_CR_FREEZE   0
`define CFG_CR_QUAD     1
`define CFG_CR_PARAMETER_SECTOR_LOCATION   2
`define CFG_CR_PROTECT_BITS_VOLATILITY     3
`define CFG_CR_PROTECT_ORIGIN_SELECT   5
`define CFG_CR_LC_LO    6
`define CFG_CR_LC_HI    7
// Status register one field positions
`define CFG_SR_WEL      1
`define CFG_SR_BP_LO    2
`define CFG_SR_BP_HI    4
`define CFG_SR_PERR     6

// Reset values
`define CFG_CR1_RST     8'h00
`define CFG_BP_RST      3'h0
`define CFG_BP_VOL_RST  3'h7

// Synchronised pin slots
`define CFG_PIN_SCK     0
`define CFG_PIN_CS      1
`define CFG_PIN_SI      2
`define CFG_PIN_WP      3
`define CFG_PIN_HOLD    4
`define CFG_PIN_HWR     5
`define CFG_PIN_RST     6'h3a

// Dummy counts per latency code, nibble index = code value
`define CFG_DUM_READ    16'h0000
`define CFG_DUM_FR      16'h0888
`define CFG_DUM_DIO     16'h0210
`define CFG_DUM_QIO     16'h1544
`define CFG_DUM_DFR     16'h1542
`define CFG_DUM_DDIO    16'h2654
`define CFG_DUM_DQIO    16'h3876
// Mode cycle counts
`define CFG_MODE_NONE   3'h0
`define CFG_MODE_DIO    3'h4
`define CFG_MODE_QIO    3'h2
`define CFG_MODE_DFR    3'h4
`define CFG_MODE_DDIO   3'h2
`define CFG_MODE_DQIO   3'h1

`endif

// >>> inc/cfg_pkg.sv
// Types for the configuration register one block
package cfg_pkg;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_OPC  = 5'h02,
        ST_WDAT = 5'h04,
        ST_RDAT = 5'h08,
        ST_SKIP = 5'h10
    } cfg_state_e_t;

    typedef struct packed {
        logic [5:0]   s0;
        logic [5:0]   s1;
        logic [5:0]   s2;
        logic [5:0]   filt;
        cfg_state_e_t st;
        logic [2:0]   bitc;
        logic [7:0]   sh;
        logic [7:0]   op;
        logic [1:0]   nbytes;
        logic [7:0]   sr_new;
        logic [7:0]   cr_new;
        logic         lat_req;
        logic         so;
        logic         so_oe;
        logic         wel;
        logic         perr;
        logic [2:0]   bp;
        logic [1:0]   lc;
        logic         protect_origin_select;
        logic         protect_bits_volatility;
        logic         parameter_sector_location;
        logic         quad;
        logic         freeze;
    } cfg_top_state_t;

    typedef struct packed {
        logic       valid;
        logic [2:0] mode;
        logic [3:0] dummy;
    } cfg_lat_state_t;

endpackage

// >>> inc/cfg_lat_if.sv
// Latency lookup request and answer between the front end and the table
`timescale 1ns/1ns
`default_nettype none
interface cfg_lat_if;
    logic [7:0] opcode;
    logic [1:0] lc;
    logic       req;
    logic       valid;
    logic [2:0] mode;
    logic [3:0] dummy;
    modport req_side (output opcode, output lc, output req, input valid, input mode, input dummy);
    modport tbl_side (input opcode, input lc, input req, output valid, output mode, output dummy);
endinterface
`default_nettype wire

// >>> design/cfg_lat_table.sv
// Mode and dummy cycle table for the enhanced read commands
`timescale 1ns/1ns
`default_nettype none
`include "cfg_defines.svh"
module cfg_lat_table (
    input  wire logic   clk,  // System clock
    input  wire logic   rst_n, // Synchronous reset, active low
    cfg_lat_if.tbl_side lat   // Lookup request and answer
);
    cfg_pkg::cfg_lat_state_t q;
    cfg_pkg::cfg_lat_state_t d;

    function automatic logic [7:0] lat_lookup(input logic [7:0] op, input logic [1:0] lc);
        logic [15:0] tbl;
        logic [2:0]  mode;
        logic        ok;
        tbl  = `CFG_DUM_READ;
        mode = `CFG_MODE_NONE;
        ok   = 1'b1;
        case (op)
            `CFG_OP_READ3, `CFG_OP_READ4: tbl = `CFG_DUM_READ;
            `CFG_OP_FR3, `CFG_OP_FR4, `CFG_OP_DOR3, `CFG_OP_DOR4,
            `CFG_OP_QOR3, `CFG_OP_QOR4: tbl = `CFG_DUM_FR;
            `CFG_OP_DIO3, `CFG_OP_DIO4: begin
                tbl  = `CFG_DUM_DIO;
                mode = `CFG_MODE_DIO;
            end
            `CFG_OP_QIO3, `CFG_OP_QIO4: begin
                tbl  = `CFG_DUM_QIO;
                mode = `CFG_MODE_QIO;
            end
            `CFG_OP_DFR3, `CFG_OP_DFR4: begin
                tbl  = `CFG_DUM_DFR;
                mode = `CFG_MODE_DFR;
            end
            `CFG_OP_DDIO3, `CFG_OP_DDIO4: begin
                tbl  = `CFG_DUM_DDIO;
                mode = `CFG_MODE_DDIO;
            end
            `CFG_OP_DQIO3, `CFG_OP_DQIO4: begin
                tbl  = `CFG_DUM_DQIO;
                mode = `CFG_MODE_DQIO;
            end
            default: ok = 1'b0;
        endcase
        return {ok, mode, tbl[{lc, 2'b00} +: 4]};
    endfunction

    always_comb begin
        d = q;
        if (lat.req) begin
            d = lat_lookup(lat.opcode, lat.lc);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign lat.valid = q.valid;
    assign lat.mode  = q.mode;
    assign lat.dummy = q.dummy;

    a_fast_code3: assert property (@(posedge clk) disable iff (!rst_n)
        lat.req && lat.opcode == `CFG_OP_QOR3 && lat.lc == 2'h3 |=> lat.mode == 3'h0 && lat.dummy == 4'h0)
        else $error("quad out read code 11 latency wrong");
    a_fast_other: assert property (@(posedge clk) disable iff (!rst_n)
        lat.req && lat.opcode == `CFG_OP_FR3 && lat.lc != 2'h3 |=> lat.valid && lat.dummy == 4'h8)
        else $error("fast read needs 8 dummy cycles");
    a_qio_latency: assert property (@(posedge clk) disable iff (!rst_n)
        lat.req && lat.opcode == `CFG_OP_QIO3 |=> lat.mode == 3'h2 &&
        lat.dummy == ($past(lat.lc) == 2'h3 ? 4'h1 : ($past(lat.lc) == 2'h2 ? 4'h5 : 4'h4)))
        else $error("quad io read latency wrong");
    a_dio_latency: assert property (@(posedge clk) disable iff (!rst_n)
        lat.req && lat.opcode == `CFG_OP_DIO4 && lat.lc == 2'h2 |=> lat.mode == 3'h4 && lat.dummy == 4'h2)
        else $error("dual io read latency wrong");
    a_ddr_fast: assert property (@(posedge clk) disable iff (!rst_n)
        lat.req && lat.opcode == `CFG_OP_DFR3 && lat.lc == 2'h2 |=> lat.mode == 3'h4 && lat.dummy == 4'h5)
        else $error("ddr fast read latency wrong");
    a_ddr_quad: assert property (@(posedge clk) disable iff (!rst_n)
        lat.req && lat.opcode == `CFG_OP_DQIO3 && lat.lc == 2'h0 |=> lat.mode == 3'h1 && lat.dummy == 4'h6)
        else $error("ddr quad io read latency wrong");
endmodule
`default_nettype wire

// >>> design/cfg_reg_top.sv
// Configuration register one: serial command slave, protection, quad and freeze logic
`timescale 1ns/1ns
`default_nettype none
`include "cfg_defines.svh"
module cfg_reg_top #(
    parameter bit       ENHANCED  = 1'b1,            // Enhanced latency tables
    parameter bit       UNIFORM   = 1'b0,            // Uniform 256-KB sector build
    parameter bit [7:0] NV_CR1    = `CFG_CR1_RST,    // Stored non-volatile configuration
    parameter bit [2:0] NV_BP     = `CFG_BP_RST      // Stored non-volatile block protect
) (
    input  wire logic       clk,                 // System clock, 25 MHz
    input  wire logic       rst_n,               // Power-on reset, synchronous, active low
    input  wire logic       sck,                 // Serial clock pin
    input  wire logic       cs_n,                // Chip select pin, active low
    input  wire logic       si,                  // Serial data in pin
    input  wire logic       wp_n,                // Write-protect pin or quad_data_line_2
    input  wire logic       hold_n,              // Pause pin or quad_data_line_3
    input  wire logic       hw_reset_n,          // Hardware reset pin, active low
    output logic            so,                  // Serial data out
    output logic            so_oe,               // Serial data out enable
    output logic            wp_n_eff,            // Write-protect function seen inside
    output logic            hold_n_eff,          // Pause function seen inside
    output logic [1:0]      latency_code,        // Latency code field
    output logic            protect_from_bottom, // Protected region starts at zero
    output logic [2:0]      block_protect_bits,  // Block-protect bits
    output logic            bp_volatile,         // Block-protect bits are volatile
    output logic            param_at_top,        // Small sectors at top of array
    output logic            quad_mode,           // Four-bit data width
    output logic            freeze_lock,         // Protection and OTP locked
    output logic            prog_error,          // Program error flag
    output logic            write_enable,        // Write enable latch
    output logic [7:0]      rd_opcode,           // Last received opcode
    output logic            rd_valid,            // Opcode is a known read
    output logic [2:0]      rd_mode,             // Mode cycles for that read
    output logic [3:0]      rd_dummy             // Dummy cycles for that read
);
    if (ENHANCED != 1'b1) begin : g_check
        $error("only the enhanced latency tables are built");
    end

    cfg_pkg::cfg_top_state_t q;
    cfg_pkg::cfg_top_state_t d;
    cfg_lat_if               lat_bus ();

    logic [5:0] pins;
    logic [5:0] agree;
    logic [5:0] rise;
    logic [5:0] fall;
    logic       sck_rise;
    logic       sck_fall;
    logic       hw_rst;
    logic [7:0] nb;
    logic [7:0] sr_val;
    logic [7:0] cr_val;
    logic       exec;
    logic       do_write;
    logic       otp_fail;
    logic       perr_set;
    logic       perr_clr;
    logic       soft_rst;

    assign pins     = {hw_reset_n, hold_n, wp_n, si, cs_n, sck};
    assign agree    = ~(q.s1 ^ q.s2);
    assign rise     = agree & q.s1 & ~q.filt;
    assign fall     = agree & ~q.s1 & q.filt;
    assign sck_rise = rise[`CFG_PIN_SCK] & ~q.filt[`CFG_PIN_CS];
    assign sck_fall = fall[`CFG_PIN_SCK] & ~q.filt[`CFG_PIN_CS];
    assign hw_rst   = ~q.filt[`CFG_PIN_HWR];
    assign nb       = {q.sh[6:0], q.s2[`CFG_PIN_SI]};
    assign sr_val   = {1'b0, q.perr, 1'b0, q.bp, q.wel, 1'b0};
    assign cr_val   = {q.lc, q.protect_origin_select, 1'b0, q.protect_bits_volatility, q.parameter_sector_location, q.quad, q.freeze};
    // Commands act at chip-select release, and only on whole bytes
    assign exec     = rise[`CFG_PIN_CS] & (q.st != cfg_pkg::ST_IDLE) & (q.st != cfg_pkg::ST_OPC)
                      & (q.bitc == 3'h0);
    assign do_write = exec & (q.op == `CFG_OP_WRR) & (q.st == cfg_pkg::ST_WDAT) & (q.nbytes != 2'h0);
    // Frozen origin and parameter bits are ignored rather than failed
    assign otp_fail = do_write & (q.nbytes == 2'h2) &
                      ((q.protect_bits_volatility & ~q.cr_new[`CFG_CR_PROTECT_BITS_VOLATILITY]) |
                       (~q.freeze & ((q.protect_origin_select & ~q.cr_new[`CFG_CR_PROTECT_ORIGIN_SELECT]) |
                                     (q.parameter_sector_location & ~q.cr_new[`CFG_CR_PARAMETER_SECTOR_LOCATION]))));
    assign perr_set = otp_fail;
    assign perr_clr = exec & ((q.op == `CFG_OP_CLSR) | (q.op == `CFG_OP_RESET));
    assign soft_rst = exec & (q.op == `CFG_OP_RESET);

    always_comb begin
        d         = q;
        d.s0      = pins;
        d.s1      = q.s0;
        d.s2      = q.s1;
        d.lat_req = 1'b0;
        for (int i = 0; i < 6; i++) begin
            if (q.s1[i] == q.s2[i]) begin
                d.filt[i] = q.s1[i];
            end
        end
        if (fall[`CFG_PIN_CS]) begin
            d.st     = cfg_pkg::ST_OPC;
            d.bitc   = 3'h0;
            d.nbytes = 2'h0;
        end else if (rise[`CFG_PIN_CS]) begin
            d.st = cfg_pkg::ST_IDLE;
        end else if (sck_rise) begin
            d.bitc = q.bitc + 3'h1;
            if (q.st != cfg_pkg::ST_RDAT) begin
                d.sh = nb;
            end
            if (q.bitc == 3'h7) begin
                unique case (q.st)
                    cfg_pkg::ST_IDLE: begin
                    end
                    cfg_pkg::ST_OPC: begin
                        d.op      = nb;
                        d.lat_req = 1'b1;
                        d.st      = cfg_pkg::ST_SKIP;
                        if (nb == `CFG_OP_WRR && q.wel) begin
                            d.st = cfg_pkg::ST_WDAT;
                        end else if (nb == `CFG_OP_RDSR) begin
                            d.st = cfg_pkg::ST_RDAT;
                            d.sh = sr_val;
                        end else if (nb == `CFG_OP_RDCR) begin
                            d.st = cfg_pkg::ST_RDAT;
                            d.sh = cr_val;
                        end
                    end
                    cfg_pkg::ST_WDAT: begin
                        if (q.nbytes == 2'h0) begin
                            d.sr_new = nb;
                        end else if (q.nbytes == 2'h1) begin
                            d.cr_new = nb;
                        end
                        if (q.nbytes != 2'h2) begin
                            d.nbytes = q.nbytes + 2'h1;
                        end
                    end
                    cfg_pkg::ST_RDAT: begin
                        d.sh = (q.op == `CFG_OP_RDSR) ? sr_val : cr_val;
                    end
                    cfg_pkg::ST_SKIP: begin
                    end
                endcase
            end
        end else if (sck_fall && q.st == cfg_pkg::ST_RDAT) begin
            d.so = q.sh[7];
            d.sh = {q.sh[6:0], 1'b0};
        end
        d.so_oe = (d.st == cfg_pkg::ST_RDAT);

        if (exec && q.op == `CFG_OP_WREN) begin
            d.wel = 1'b1;
        end
        if (exec && q.op == `CFG_OP_WRDI) begin
            d.wel = 1'b0;
        end
        if (do_write) begin
            d.wel = 1'b0;
            if (!otp_fail) begin
                if (!q.freeze) begin
                    d.bp = q.sr_new[`CFG_SR_BP_HI:`CFG_SR_BP_LO];
                end
                if (q.nbytes == 2'h2) begin
                    d.lc   = q.cr_new[`CFG_CR_LC_HI:`CFG_CR_LC_LO];
                    d.quad = q.cr_new[`CFG_CR_QUAD];
                    d.protect_bits_volatility = q.protect_bits_volatility | q.cr_new[`CFG_CR_PROTECT_BITS_VOLATILITY];
                    if (!q.freeze) begin
                        d.protect_origin_select = q.cr_new[`CFG_CR_PROTECT_ORIGIN_SELECT];
                        d.parameter_sector_location = q.cr_new[`CFG_CR_PARAMETER_SECTOR_LOCATION];
                    end
                    // Old freeze guards this write; new freeze lands with the rest
                    d.freeze = q.freeze | q.cr_new[`CFG_CR_FREEZE];
                end
            end
        end
        d.perr = (q.perr & ~perr_clr) | perr_set;
        if (soft_rst) begin
            d.wel = 1'b0;
            if (q.protect_bits_volatility) begin
                d.bp = `CFG_BP_VOL_RST;
            end
        end
        if (hw_rst) begin
            d.st     = cfg_pkg::ST_IDLE;
            d.so_oe  = 1'b0;
            d.wel    = 1'b0;
            d.perr   = 1'b0;
            d.freeze = 1'b0;
            if (q.protect_bits_volatility) begin
                d.bp = `CFG_BP_VOL_RST;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q        <= '0;
            // All three stages start at the idle pin levels, so no false edge follows reset
            q.s0     <= `CFG_PIN_RST;
            q.s1     <= `CFG_PIN_RST;
            q.s2     <= `CFG_PIN_RST;
            q.filt   <= `CFG_PIN_RST;
            q.st     <= cfg_pkg::ST_IDLE;
            q.lc     <= NV_CR1[`CFG_CR_LC_HI:`CFG_CR_LC_LO];
            q.protect_origin_select <= NV_CR1[`CFG_CR_PROTECT_ORIGIN_SELECT];
            q.protect_bits_volatility   <= NV_CR1[`CFG_CR_PROTECT_BITS_VOLATILITY];
            q.parameter_sector_location <= NV_CR1[`CFG_CR_PARAMETER_SECTOR_LOCATION];
            q.quad   <= NV_CR1[`CFG_CR_QUAD];
            q.bp     <= NV_CR1[`CFG_CR_PROTECT_BITS_VOLATILITY] ? `CFG_BP_VOL_RST : NV_BP;
        end else begin
            q <= d;
        end
    end

    assign lat_bus.req    = q.lat_req;
    assign lat_bus.opcode = q.op;
    assign lat_bus.lc     = q.lc;

    cfg_lat_table u_table (
        .clk   (clk),
        .rst_n (rst_n),
        .lat   (lat_bus)
    );

    assign so                  = q.so;
    assign so_oe               = q.so_oe;
    assign wp_n_eff            = q.quad | q.filt[`CFG_PIN_WP];
    assign hold_n_eff          = q.quad | q.filt[`CFG_PIN_HOLD];
    assign latency_code        = q.lc;
    assign protect_from_bottom = q.protect_origin_select;
    assign block_protect_bits  = q.bp;
    assign bp_volatile         = q.protect_bits_volatility;
    assign param_at_top        = q.parameter_sector_location & ~UNIFORM;
    assign quad_mode           = q.quad;
    assign freeze_lock         = q.freeze;
    assign prog_error          = q.perr;
    assign write_enable        = q.wel;
    assign rd_opcode           = q.op;
    assign rd_valid            = lat_bus.valid;
    assign rd_mode             = lat_bus.mode;
    assign rd_dummy            = lat_bus.dummy;

    a_quad_pins: assert property (@(posedge clk) disable iff (!rst_n)
        q.quad && $past(q.quad) && !$past(q.filt[`CFG_PIN_WP]) |-> wp_n_eff && hold_n_eff)
        else $error("quad mode must hold pin functions high");
    a_freeze_stays: assert property (@(posedge clk) disable iff (!rst_n)
        q.freeze && q.filt[`CFG_PIN_HWR] |=> q.freeze)
        else $error("freeze cleared without hardware reset");
    a_bp_frozen: assert property (@(posedge clk) disable iff (!rst_n)
        q.freeze && q.filt[`CFG_PIN_HWR] && !q.protect_bits_volatility |=> $stable(q.bp) && $stable(q.protect_origin_select) && $stable(q.parameter_sector_location))
        else $error("frozen field changed");
    a_otp_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        q.protect_bits_volatility || q.protect_origin_select |=> (q.protect_bits_volatility || !$past(q.protect_bits_volatility)) && (q.protect_origin_select || !$past(q.protect_origin_select)))
        else $error("one-time bit returned to zero");
    a_perr_on_fail: assert property (@(posedge clk) disable iff (!rst_n)
        otp_fail |=> q.perr && $stable(q.lc))
        else $error("failed write not flagged or not refused");
    a_bp_reload: assert property (@(posedge clk) disable iff (!rst_n)
        hw_rst && q.protect_bits_volatility |=> q.bp == 3'h7 && !q.freeze)
        else $error("volatile protect bits not reloaded");
    a_uniform_param: assert property (@(posedge clk) disable iff (!rst_n)
        UNIFORM |-> !param_at_top)
        else $error("parameter bit active in uniform build");
    a_freeze_joint: assert property (@(posedge clk) disable iff (!rst_n)
        do_write && !otp_fail && !hw_rst && q.nbytes == 2'h2 && q.cr_new[0] |=>
        q.freeze && q.lc == $past(q.cr_new[7:6]) && q.quad == $past(q.cr_new[1]))
        else $error("freeze not applied with the other bits");
endmodule
`default_nettype wire

// >>> test/cfg_host_model.sv
// Host serial controller model that frames commands on the link
`timescale 1ns/1ns
`default_nettype none
module cfg_host_model (
    output var logic sck,  // Serial clock, stands low outside frames
    output var logic cs_n, // Chip select, active low
    output var logic si,   // Serial data to the device
    input  wire logic so   // Serial data from the device
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // Sends n bytes MSB first from the top of d, returns the last byte read
    task automatic frame(input logic [23:0] d, input int n, output logic [7:0] r);
        cs_n = 1'b0;
        for (int i = 0; i < n * 8; i++) begin
            si = d[23-i];
            #160 sck = 1'b1;
            #80 r = {r[6:0], so};
            #80 sck = 1'b0;
        end
        #160 cs_n = 1'b1;
        // Released line shows no stale value
        si = ~si;
        #400;
    endtask
endmodule
`default_nettype wire

// >>> test/cfg_reg_top_tb_top.sv
// Testbench for the configuration register one block
`timescale 1ns/1ns
`default_nettype none
`include "cfg_defines.svh"
module cfg_reg_top_tb_top;
    logic       clk, rst_n, sck, cs_n, si, wp_n, hold_n, hw_reset_n, so, so_oe, wp_n_eff, hold_n_eff;
    logic       protect_from_bottom, bp_volatile, param_at_top, quad_mode, freeze_lock, prog_error;
    logic       write_enable, rd_valid;
    logic [1:0] latency_code;
    logic [2:0] block_protect_bits, rd_mode;
    logic [3:0] rd_dummy;
    logic [7:0] rd_opcode, r, cfg_obs, sr_obs;
    int         failures, checks;
    // Opcode, valid flag with mode, dummies for codes 00, 01, 10, 11
    logic [27:0] tbl [9] = '{28'h0380000, 28'h0b88880, 28'h3b88880, 28'h6b88880, 28'hbbc0120,
                             28'heba4451, 28'h0dc2451, 28'hbda4562, 28'hed96783};
    assign cfg_obs = {latency_code, protect_from_bottom, 1'b0, bp_volatile, param_at_top, quad_mode, freeze_lock};
    assign sr_obs = {1'b0, prog_error, 1'b0, block_protect_bits, write_enable, 1'b0};
    cfg_host_model i_cfg_host_model (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
    cfg_reg_top i_cfg_reg_top (.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
        .hold_n(hold_n), .hw_reset_n(hw_reset_n), .so(so), .so_oe(so_oe), .wp_n_eff(wp_n_eff),
        .hold_n_eff(hold_n_eff), .latency_code(latency_code), .protect_from_bottom(protect_from_bottom),
        .block_protect_bits(block_protect_bits), .bp_volatile(bp_volatile), .param_at_top(param_at_top),
        .quad_mode(quad_mode), .freeze_lock(freeze_lock), .prog_error(prog_error),
        .write_enable(write_enable), .rd_opcode(rd_opcode), .rd_valid(rd_valid), .rd_mode(rd_mode),
        .rd_dummy(rd_dummy));
    initial begin
        clk = 1'b0;
        #7;
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic write_registers_cmd(input logic [7:0] s, input logic [7:0] c);
        i_cfg_host_model.frame({`CFG_OP_WREN, 16'h0000}, 1, r);
        i_cfg_host_model.frame({`CFG_OP_WRR, s, c}, 3, r);
    endtask
    task automatic done(input string name);
        $display("test %s done", name);
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        failures++;
        end_of_test();
    end
    initial begin
        failures = 0;
        checks = 0;
        rst_n = 1'b0;
        wp_n = 1'b0;
        hold_n = 1'b0;
        hw_reset_n = 1'b1;
        repeat (4) @(posedge clk);
        #2 rst_n = 1'b1;
        repeat (8) @(posedge clk);
        chk(cfg_obs, 8'h00);
        chk({6'h00, wp_n_eff, hold_n_eff}, 8'h00);
        done("reset");
        write_registers_cmd(8'h1c, 8'h43);
        chk(cfg_obs, 8'h43);
        chk(sr_obs, 8'h1c);
        chk({6'h00, wp_n_eff, hold_n_eff}, 8'h03);
        i_cfg_host_model.frame({`CFG_OP_RDCR, 16'h0000}, 2, r);
        chk(r, 8'h43);
        done("freeze with config");
        // Quad is already set before any quad read
        // No learning pattern is requested, so every latency code is legal here
        for (int c = 0; c < 4; c++) begin
            write_registers_cmd(8'h1c, {c[1:0], 6'h03});
            chk({6'h00, latency_code}, {6'h00, c[1:0]});
            for (int k = 0; k < 9; k++) begin
                i_cfg_host_model.frame({tbl[k][27:20], 16'h0000}, 1, r);
                chk({rd_valid, rd_mode, rd_dummy}, {tbl[k][19:16], tbl[k][15-4*c -: 4]});
                chk(rd_opcode, tbl[k][27:20]);
            end
        end
        done("latency tables");
        write_registers_cmd(8'h00, 8'h24);
        chk(cfg_obs, 8'h01);
        chk(sr_obs, 8'h1c);
        i_cfg_host_model.frame({`CFG_OP_RESET, 16'h0000}, 1, r);
        chk(cfg_obs, 8'h01);
        done("frozen write and soft reset");
        @(posedge clk);
        #2 hw_reset_n = 1'b0;
        repeat (10) @(posedge clk);
        #2 hw_reset_n = 1'b1;
        repeat (10) @(posedge clk);
        chk(cfg_obs, 8'h00);
        done("hardware reset");
        // Origin and parameter bits chosen before any array program
        write_registers_cmd(8'h00, 8'h2c);
        chk(cfg_obs, 8'h2c);
        chk(sr_obs, 8'h00);
        write_registers_cmd(8'h00, 8'h00);
        chk(cfg_obs, 8'h2c);
        chk(sr_obs, 8'h40);
        i_cfg_host_model.frame({`CFG_OP_RESET, 16'h0000}, 1, r);
        chk(sr_obs, 8'h1c);
        done("one-time bits and volatility");
        end_of_test();
    end
endmodule
`default_nettype wire
